//--- verilog/reload_timer_cfg.svh
// register offsets, field positions, reset values and timing counts of the reload timer
// assumes inclusion by bare name from the package, whose macros the design modules use
`ifndef RELOAD_TIMER_CFG_SVH
`define RELOAD_TIMER_CFG_SVH

`define ADDR_NVM_CONTROL 8'h04
`define ADDR_TIMER_RELOAD 8'h05
`define ADDR_TIMER_COUNT 8'h06
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_MASK 8'h09

`define BIT_TIMER_RUN 7
`define BIT_IRQ_ENABLE 6
`define BIT_UNDERFLOW 5
`define BIT_CYCLE_START 4
`define BIT_MODE_C 3
`define BIT_MODE_B 2
`define BIT_MODE_A 1

`define RST_NVM_CONTROL 8'h00
`define RST_TIMER_RELOAD 8'h00
`define RST_TIMER_COUNT 8'h00
`define RST_IRQ_STATUS 2'h0
`define RST_IRQ_MASK 2'h0

`define TICK_DIVIDE 480

`endif

//--- verilog/reload_timer_pkg.sv
// types shared by the reload timer design files
// assumes the cfg header is on the include path
package reload_timer_pkg;
  `include "reload_timer_cfg.svh"

  // what the counter is timing
  typedef enum logic [1:0] {
    mode_idle,
    mode_general,
    mode_nvm_first,
    mode_nvm_last
  } timer_mode_t;
endpackage : reload_timer_pkg

//--- verilog/tick_divider.sv
// divide-by-n tick prescaler producing a one-cycle enable pulse
// assumes one clock domain and a synchronous active-low reset
module tick_divider
  import reload_timer_pkg::*;
#(
  parameter int DIVIDE = `TICK_DIVIDE
)
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic enable_in,
  input wire logic restart_in,
  output logic tick_out
);
  localparam int CW = $clog2(DIVIDE);

  // elaboration check: a divide below two cannot make a one-cycle pulse
  if (DIVIDE < 2)
  begin : g_divide_check
    $error("tick_divider: DIVIDE must be at least 2");
  end

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic tick_reg;
  wire at_end = (count_reg == CW'(DIVIDE - 1));

  // counts only while enabled, restarts from zero on a timer start
  assign count_next = restart_in ? '0 : (!enable_in ? count_reg : (at_end ? '0 : count_reg + 1'b1));

  // prescaler state and tick pulse
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      tick_reg <= enable_in && !restart_in && at_end;
    end
  end

  assign tick_out = tick_reg;
endmodule : tick_divider

//--- verilog/wake_sync.sv
// three-stage synchroniser with agreement filter for an asynchronous pin
// assumes the pin is unrelated to clk_in
module wake_sync
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic pin_in,
  output logic level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  // first stage feeds only the second; level moves once stages two and three agree
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        level_reg <= s3_reg;
    end
  end

  assign level_out = level_reg;
endmodule : wake_sync

//--- verilog/reload_timer.sv
// reloadable 8-bit down timer with underflow flag, interrupt and memory-cycle timing
// assumes a core-side register port with read data one cycle after the read strobe;
// stop mode is modelled by stop_mode_in setting asleep_reg, which gates the timer clock enable until a high wake level
//
// Operation
// RULE1: run bit loads reload, then decrements per tick
// RULE2: general underflow reloads, flags, keeps counting
// RULE3: clearing run bit freezes count for readback
// RULE4: restart counts from reload value, not held
// RULE5: count readable anytime without disturbing it
// RULE6: flag and enable in control register
// RULE7: interrupt request from set flag and enable
// RULE8: software clears flag explicitly; may poll it
// RULE9: software writing flag one raises interrupt
// RULE10: reset clears all registers to zero; awake_reg resets to one
// RULE11: idle mode keeps timer and cycle running
// RULE12: stop mode freezes timer, resumes after wake
// RULE13: software avoids stop during memory cycle
// RULE14: reload at 05 rw, counter 06 read-only
// RULE15: counter decrements every 480 crystal periods
// RULE16: final memory underflow stops, flags, clears bits
// RULE17: cycle start loads; erase-write reloads once
// RULE18: counter writes ignored; control bit0 reads zero
// RULE19: prescaler runs only while timing, restarts on start
//
// Chosen here: the plain strobed port.
module reload_timer
  import reload_timer_pkg::*;
#(
  parameter int TICK_DIV = `TICK_DIVIDE
)
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic idle_mode_in,
  input wire logic stop_mode_in,
  input wire logic wake_pin_in,
  output logic [7:0] rdata_out,
  output logic irq_out,
  output logic irq_request_out,
  output logic awake_out
);
  // elaboration check: the counter and its cycle figures assume this divide
  if (TICK_DIV != `TICK_DIVIDE)
  begin : g_div_check
    $error("reload_timer: tick divide other than 480 is not served");
  end

  logic [7:0] control_reg;
  logic [7:0] control_next;
  logic [7:0] reload_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [1:0] status_reg;
  logic [1:0] status_next;
  logic [1:0] mask_reg;
  logic irq_reg;
  logic irq_request_reg;
  logic asleep_reg;
  logic awake_reg;
  logic second_pass_reg;
  logic second_pass_next;
  timer_mode_t mode;
  logic tick;
  logic wake_level;

  // register decode
  wire wr_control = wr_in && (addr_in == `ADDR_NVM_CONTROL);
  wire wr_reload = wr_in && (addr_in == `ADDR_TIMER_RELOAD);
  wire wr_status = wr_in && (addr_in == `ADDR_IRQ_STATUS);
  wire wr_mask = wr_in && (addr_in == `ADDR_IRQ_MASK);

  // run and cycle-start edges from control writes
  wire run_now = control_reg[`BIT_TIMER_RUN];
  wire cycle_now = control_reg[`BIT_CYCLE_START];
  wire run_set = wr_control && wdata_in[`BIT_TIMER_RUN] && !run_now;
  wire cycle_set = wr_control && wdata_in[`BIT_CYCLE_START] && !cycle_now;
  wire start = run_set || cycle_set;
  wire erase_write = control_reg[`BIT_MODE_C] && !control_reg[`BIT_MODE_B];

  // stop mode gates every timer clock enable; idle mode does not
  wire clock_on = !asleep_reg; // see RULE11 see RULE12
  wire timing = (run_now || cycle_now) && clock_on;
  wire tick_ok = tick && clock_on;
  wire underflow = tick_ok && (count_reg == 8'h00);

  assign mode = cycle_now ? (erase_write && !second_pass_reg ? mode_nvm_first : mode_nvm_last)
              : (run_now ? mode_general : mode_idle);

  // end of a memory cycle on its final underflow
  wire cycle_done = underflow && (mode == mode_nvm_last); // see RULE16
  wire sw_flag_set = wr_control && wdata_in[`BIT_UNDERFLOW]; // see RULE9
  // a first erase pass only reloads; general underflows and the final pass flag
  wire flag_set = underflow && (mode == mode_general || mode == mode_nvm_last); // see RULE16

  tick_divider #(
    .DIVIDE(TICK_DIV)
  ) u_div (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .enable_in(timing), // see RULE19
    .restart_in(start), // see RULE19
    .tick_out(tick) // see RULE15
  );

  wake_sync u_wake (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .pin_in(wake_pin_in),
    .level_out(wake_level)
  );

  // control register: software write, then hardware set wins over software clear
  always_comb
  begin
    control_next = control_reg;
    if (wr_control)
      control_next = {wdata_in[7:1], 1'b0}; // see RULE18 see RULE6
    if (flag_set)
      control_next[`BIT_UNDERFLOW] = 1'b1; // see RULE2 see RULE8
    if (cycle_done)
    begin
      control_next[`BIT_CYCLE_START] = 1'b0; // see RULE16
      control_next[`BIT_MODE_C] = 1'b0;
      control_next[`BIT_MODE_B] = 1'b0;
      control_next[`BIT_MODE_A] = 1'b0;
    end
  end

  // counter: load on start, hold when stopped, reload on underflow
  always_comb
  begin
    count_next = count_reg;
    second_pass_next = second_pass_reg;
    if (start)
    begin
      count_next = reload_reg; // see RULE1 see RULE4 see RULE17
      second_pass_next = 1'b0;
    end
    else if (underflow && !cycle_done && mode != mode_idle)
    begin
      count_next = reload_reg; // see RULE2 see RULE17
      if (mode == mode_nvm_first)
        second_pass_next = 1'b1;
    end
    else if (tick_ok && timing && !underflow)
      count_next = count_reg - 8'h01; // see RULE1
    // a finished memory cycle holds zero instead of wrapping
    // clearing run leaves count untouched
    // see RULE3
  end

  // interrupt status: underflow and wake events, write one to clear, set wins
  assign status_next = (status_reg & ~(wr_status ? wdata_in[1:0] : 2'h0))
                     | {wake_level && asleep_reg, flag_set || sw_flag_set};

  // read data mux; counter read has no side effect
  always_comb
  begin
    unique case (addr_in)
      `ADDR_NVM_CONTROL: rdata_next = {control_reg[7:1], 1'b0}; // see RULE18
      `ADDR_TIMER_RELOAD: rdata_next = reload_reg; // see RULE14
      `ADDR_TIMER_COUNT: rdata_next = count_reg; // see RULE5 see RULE14
      `ADDR_IRQ_STATUS: rdata_next = {6'h00, status_reg};
      `ADDR_IRQ_MASK: rdata_next = {6'h00, mask_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  // stop entered by the core; left only on a high wake level
  wire sleep_enter = stop_mode_in && !asleep_reg; // see RULE12 see RULE13
  wire sleep_leave = asleep_reg && wake_level; // see RULE12
  wire awake_next = !(asleep_reg && !wake_level) && !sleep_enter;

  // request to the core: flag and enable, arbitration stays in the core
  wire irq_request_next = control_next[`BIT_UNDERFLOW] && control_next[`BIT_IRQ_ENABLE];
  wire irq_next = |(status_next & mask_reg);

  // control register; reset clears every register of the block but awake_reg, which it sets to one
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      control_reg <= `RST_NVM_CONTROL; // see RULE10
    else
      control_reg <= control_next;
  end

  // reload register, written only by software
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      reload_reg <= `RST_TIMER_RELOAD; // see RULE10
    else if (wr_reload)
      reload_reg <= wdata_in; // see RULE14
  end

  // counter and pass tracker; no write path from the bus
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      count_reg <= `RST_TIMER_COUNT; // see RULE10
      second_pass_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next; // see RULE18
      second_pass_reg <= second_pass_next;
    end
  end

  // interrupt status and mask
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      status_reg <= `RST_IRQ_STATUS;
      mask_reg <= `RST_IRQ_MASK;
    end
    else
    begin
      status_reg <= status_next;
      if (wr_mask)
        mask_reg <= wdata_in[1:0];
    end
  end

  // read data stand for one cycle only, zero otherwise
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      rdata_reg <= 8'h00;
    else if (rd_in)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= 8'h00;
  end

  // sleep state and awake flag
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      asleep_reg <= 1'b0;
      awake_reg <= 1'b1;
    end
    else
    begin
      if (sleep_enter)
        asleep_reg <= 1'b1;
      else if (sleep_leave)
        asleep_reg <= 1'b0;
      awake_reg <= awake_next;
    end
  end

  // interrupt outputs come straight from flip-flops, one cycle after the cause
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      irq_reg <= 1'b0;
      irq_request_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= irq_next;
      irq_request_reg <= irq_request_next; // see RULE7
    end
  end

  assign rdata_out = rdata_reg;
  assign irq_out = irq_reg;
  assign irq_request_out = irq_request_reg;
  assign awake_out = awake_reg;
endmodule : reload_timer

//--- verification/core_model.sv
// core-side master for the timer's plain register port
// assumes one clock; signals change only right after a rising edge
module core_model
(
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // bus idle from time zero
  initial
  begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // one-cycle write strobe
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask : wr
  // data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    @(posedge clk_in);
    d = rdata_in;
  endtask : rd
endmodule : core_model

//--- verification/reload_timer_properties.sv
// port-level checks of the reload timer
// assumes one clock domain with synchronous active-low reset
module reload_timer_properties
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic stop_mode_in,
  input wire logic [7:0] rdata_out,
  input wire logic irq_out,
  input wire logic irq_request_out,
  input wire logic awake_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // reads are only ever one cycle late
  property p_rst;
    $past(!resetn_in) |-> rdata_out == 8'h00 && !irq_out && !irq_request_out && awake_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_reload;
    wr_in && addr_in == 8'h05 ##2 rd_in && addr_in == 8'h05 |-> ##1 rdata_out == $past(wdata_in, 3);
  endproperty
  a_reload: assert property (p_reload) else $error("reload readback wrong");
  property p_bit0;
    $past(rd_in) && $past(addr_in) == 8'h04 |-> rdata_out[0] == 1'b0;
  endproperty
  a_bit0: assert property (p_bit0) else $error("control bit0 set");
  property p_hole;
    $past(rd_in) && !($past(addr_in) inside {8'h04, 8'h05, 8'h06, 8'h08, 8'h09}) |->
      rdata_out == 8'h00;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  // request follows flag and enable as read back
  property p_req;
    $past(rd_in) && $past(addr_in) == 8'h04 |-> irq_request_out == (rdata_out[6] & rdata_out[5]);
  endproperty
  a_req: assert property (p_req) else $error("request disagrees with control");
  property p_swirq;
    wr_in && addr_in == 8'h04 && wdata_in[6:5] == 2'b11 |-> ##[1:2] irq_request_out;
  endproperty
  a_swirq: assert property (p_swirq) else $error("software request missing");
  // flag never clears by itself
  property p_sticky;
    $fell(irq_request_out) |-> $past(wr_in) && $past(addr_in) == 8'h04;
  endproperty
  a_sticky: assert property (p_sticky) else $error("request dropped alone");
  property p_sleep;
    $fell(awake_out) |-> stop_mode_in || $past(stop_mode_in);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep without stop");
  c_irq: cover property ($rose(irq_out));
  c_req: cover property ($rose(irq_request_out));
  c_wake: cover property ($rose(awake_out));
endmodule : reload_timer_properties

bind reload_timer reload_timer_properties u_props (.clk_in(clk_in), .resetn_in(resetn_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .stop_mode_in(stop_mode_in), .rdata_out(rdata_out), .irq_out(irq_out),
  .irq_request_out(irq_request_out), .awake_out(awake_out));

//--- verification/reload_timer_tb.sv
// self-checking bench of the reload timer driven through the core model
// assumes the tick divider stays at 480 clocks
module reload_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0, resetn_in = 1'b0, idle_mode_in = 1'b0;
  logic stop_mode_in = 1'b0, wake_pin_in = 1'b0;
  logic [7:0] addr_in, wdata_in, rdata_out, r, c;
  logic wr_in, rd_in, irq_out, irq_request_out, awake_out;
  logic [31:0] seed = 32'h4E5BD7FA;
  int mismatches = 0, checks = 0, n, k;
  always #12.5 clk_in = ~clk_in;
  core_model core (.clk_in(clk_in), .rdata_in(rdata_out), .addr_out(addr_in),
    .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
  reload_timer u_reload_timer (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .idle_mode_in(idle_mode_in),
    .stop_mode_in(stop_mode_in), .wake_pin_in(wake_pin_in), .rdata_out(rdata_out),
    .irq_out(irq_out), .irq_request_out(irq_request_out), .awake_out(awake_out));
  function logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // erase-then-write needs two intervals
  function logic [7:0] passes(input logic [7:0] w);
    return (w[3] && !w[2]) ? 8'h02 : 8'h01;
  endfunction : passes
  task chk8(input string s, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk8
  task chk1(input string s, input logic e, input logic g);
    chk8(s, {7'h00, e}, {7'h00, g});
  endtask : chk1
  task rdchk(input logic [7:0] a, input logic [7:0] e, input string s);
    logic [7:0] v;
    core.rd(a, v);
    chk8(s, e, v);
  endtask : rdchk
  task cyc(input int t);
    repeat (t) @(posedge clk_in);
  endtask : cyc
  task close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // bounded on the longest memory cycle
  task wait_req;
    k = 0;
    while (irq_request_out !== 1'b1 && k < 7000)
    begin
      @(posedge clk_in);
      k++;
    end
  endtask : wait_req
  // run takes about 10k cycles
  initial
  begin
    #1500000;
    mismatches++;
    close_out;
  end
  initial
  begin
    cyc(4);
    resetn_in <= 1'b1;
    seed = xs(seed);
    r = 8'h02 + (seed[7:0] & 8'h03);
    for (n = 4; n < 7; n++) rdchk(n[7:0], 8'h00, "reset");
    rdchk(8'h07, 8'h00, "hole");
    for (n = 0; n < 4; n++)
    begin
      seed = xs(seed);
      rdchk(8'h0A + seed[7:0] % 8'hF0, 8'h00, "hole");
    end
    core.wr(8'h05, r);
    rdchk(8'h05, r, "reload");
    core.wr(8'h06, seed[15:8] | 8'h01);
    rdchk(8'h06, 8'h00, "count ro");
    $display("test map done");
    // idle must not slow the count
    idle_mode_in <= 1'b1;
    core.wr(8'h04, 8'hC0);
    cyc(460);
    rdchk(8'h06, r, "load");
    cyc(30);
    rdchk(8'h06, r - 8'h01, "tick");
    rdchk(8'h04, 8'hC0, "control");
    core.wr(8'h04, 8'h40);
    cyc(600);
    rdchk(8'h06, r - 8'h01, "held");
    core.wr(8'h04, 8'hC0);
    rdchk(8'h06, r, "restart");
    cyc(458);
    rdchk(8'h06, r, "prescale");
    cyc(30);
    rdchk(8'h06, r - 8'h01, "on fly");
    wait_req;
    chk1("request", 1'b1, irq_request_out);
    rdchk(8'h06, r, "underflow");
    rdchk(8'h04, 8'hE0, "flag");
    chk1("masked", 1'b0, irq_out);
    core.wr(8'h09, 8'h01);
    cyc(2);
    chk1("unmasked", 1'b1, irq_out);
    core.wr(8'h04, 8'h40);
    core.wr(8'h08, 8'h01);
    cyc(2);
    chk1("cleared", 1'b0, irq_out);
    $display("test general done");
    core.wr(8'h04, 8'h60);
    cyc(2);
    chk1("soft irq", 1'b1, irq_out);
    core.wr(8'h04, 8'h00);
    core.wr(8'h08, 8'h01);
    core.wr(8'h04, 8'hC0);
    cyc(300);
    idle_mode_in <= 1'b0;
    stop_mode_in <= 1'b1;
    cyc(2000);
    chk1("asleep", 1'b0, awake_out);
    wake_pin_in <= 1'b1;
    stop_mode_in <= 1'b0;
    cyc(10);
    chk1("awake", 1'b1, awake_out);
    wake_pin_in <= 1'b0;
    rdchk(8'h06, r, "frozen");
    cyc(190);
    rdchk(8'h06, r - 8'h01, "resume");
    core.wr(8'h04, 8'h00);
    core.wr(8'h08, 8'h03);
    $display("test stop done");
    // single pass and erase-then-write
    for (n = 0; n < 2; n++)
    begin
      c = n ? 8'h58 : 8'h52;
      core.wr(8'h04, c);
      wait_req;
      chk8("interval", passes(c) * (r + 8'h01), 8'((k + 240) / 480));
      rdchk(8'h04, 8'h60, "cycle end");
      rdchk(8'h06, 8'h00, "cycle stop");
      core.wr(8'h04, 8'h00);
    end
    $display("test memory done");
    // reset in mid-run clears live state
    core.wr(8'h04, 8'hC0);
    cyc(2);
    resetn_in <= 1'b0;
    cyc(4);
    resetn_in <= 1'b1;
    for (n = 4; n < 7; n++) rdchk(n[7:0], 8'h00, "reset again");
    $display("test reset done");
    close_out;
  end
endmodule : reload_timer_tb
